// ---- rtca_top.sv ----
/*
 Control, tick and alarm registers of the real time clock. Byte accesses
 from the processor with address, write strobe, read strobe and endian mode.
 Assumes the time-of-day counters sit outside and present current BCD time.
*/
`timescale 1ns/1ns
`default_nettype none
module rtca_top
   import rtca_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Processor byte port
   input  wire logic [31:0] bus_addr,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   input  wire logic        bus_big_endian,
   input  wire logic [7:0]  bus_wdata,
   output logic [7:0]       bus_rdata,
   output logic             bus_rvalid,
   // Crystal and power state
   input  wire logic        xtal_edge,
   input  wire logic        power_down,
   // Current BCD time
   input  wire logic [7:0]  seconds_bcd,
   input  wire logic [7:0]  minutes_bcd,
   input  wire logic [7:0]  hours_bcd,
   input  wire logic [7:0]  day_of_month_bcd,
   input  wire logic [7:0]  month_bcd,
   input  wire logic [7:0]  year_bcd,
   // Controls for the time counters
   output logic             cpu_access_enable,
   output logic             count_chain_reset,
   output logic             counter_merge_select,
   output logic             count_clock_source,
   output logic             second_advance,
   // Interrupts
   output logic             tick_irq,
   output logic             alarm_irq,
   output logic             power_wakeup_request
);
   typedef struct packed {
      logic [7:0] rtc_control;
      logic [7:0] tick_control;
      logic [7:0] alarm_control;
      logic [7:0] alarm_second;
      logic [7:0] alarm_minute;
      logic [7:0] alarm_hour;
      logic [7:0] alarm_date;
      logic [7:0] alarm_month;
      logic [7:0] alarm_year;
      logic [7:0] rdata;
      logic       rvalid;
      logic       sec_adv;
      logic       tick_irq;
      logic       alarm_irq;
      logic       wakeup;
      logic       match_seen;
   } rtca_state_s;

   rtca_state_s st;
   rtca_state_s next_st;
   logic [31:0] le_addr;
   logic        wr_ok;
   logic        tick_load;
   logic [6:0]  tick_reload;
   logic        second_pulse;
   logic        tick_zero;
   logic [5:0]  field_ok;
   logic        alarm_match;
   rtca_bus_e   bus_op;

   // big-endian alias sits three bytes up
   assign le_addr = bus_big_endian ? (bus_addr - RTCA_BIG_OFFSET) : bus_addr;
   assign wr_ok = st.rtc_control[RTCA_BIT_ACCESS_EN];
   assign bus_op = bus_write ? RTCA_BUS_WRITE : (bus_read ? RTCA_BUS_READ : RTCA_BUS_IDLE);
   assign tick_load = (bus_op == RTCA_BUS_WRITE) && wr_ok && (le_addr == RTCA_ADDR_TICK);
   // A write reloads the count with the new byte; the register still holds the old one
   assign tick_reload = tick_load ? bus_wdata[6:0] : st.tick_control[6:0];

   rtca_tick u_tick (
      .clk_sys      (clk_sys),
      .reset        (reset),
      .xtal_edge    (xtal_edge),
      .chain_reset  (st.rtc_control[RTCA_BIT_CHAIN_RST]),
      .raw_clock    (st.rtc_control[RTCA_BIT_CLK_SRC]),
      .reload       (tick_reload),
      .reload_load  (tick_load),
      .second_pulse (second_pulse),
      .tick_zero    (tick_zero)
   );

   rtca_match u_m_sec  (.alarm_value(st.alarm_second), .time_value(seconds_bcd & RTCA_MASK_SEC),
      .field_on(st.alarm_control[RTCA_BIT_SEC_ON]), .field_ok(field_ok[0]));
   rtca_match u_m_min  (.alarm_value(st.alarm_minute), .time_value(minutes_bcd & RTCA_MASK_SEC),
      .field_on(st.alarm_control[RTCA_BIT_MIN_ON]), .field_ok(field_ok[1]));
   rtca_match u_m_hour (.alarm_value(st.alarm_hour), .time_value(hours_bcd & RTCA_MASK_HOUR),
      .field_on(st.alarm_control[RTCA_BIT_HOUR_ON]), .field_ok(field_ok[2]));
   rtca_match u_m_date (.alarm_value(st.alarm_date),
      .time_value(day_of_month_bcd & RTCA_MASK_HOUR),
      .field_on(st.alarm_control[RTCA_BIT_DATE_ON]), .field_ok(field_ok[3]));
   rtca_match u_m_mon  (.alarm_value(st.alarm_month), .time_value(month_bcd & RTCA_MASK_MON),
      .field_on(st.alarm_control[RTCA_BIT_MON_ON]), .field_ok(field_ok[4]));
   rtca_match u_m_year (.alarm_value(st.alarm_year), .time_value(year_bcd & RTCA_MASK_YEAR),
      .field_on(st.alarm_control[RTCA_BIT_YEAR_ON]), .field_ok(field_ok[5]));

   assign alarm_match = st.alarm_control[RTCA_BIT_ALM_ON] && (&field_ok);

   always_comb begin
      next_st         = st;
      next_st.rvalid  = 1'b0;
      next_st.sec_adv = second_pulse;
      next_st.tick_irq = tick_zero && st.tick_control[RTCA_BIT_TICK_IE];
      // Alarm pulses once when a match begins, so a held match is not repeated
      next_st.match_seen = alarm_match;
      next_st.alarm_irq = alarm_match && !st.match_seen;
      next_st.wakeup    = alarm_match && !st.match_seen && power_down;
      unique case (bus_op)
         RTCA_BUS_WRITE: begin
            if (wr_ok || (le_addr == RTCA_ADDR_CONTROL)) begin
               unique case (le_addr)
                  RTCA_ADDR_CONTROL:  next_st.rtc_control   = bus_wdata & RTCA_MASK_CONTROL;
                  RTCA_ADDR_TICK:     next_st.tick_control  = bus_wdata & RTCA_MASK_TICK;
                  RTCA_ADDR_ALM_CTRL: next_st.alarm_control = bus_wdata & RTCA_MASK_ALM_CTRL;
                  RTCA_ADDR_ALM_SEC:  next_st.alarm_second  = bus_wdata & RTCA_MASK_SEC;
                  RTCA_ADDR_ALM_MIN:  next_st.alarm_minute  = bus_wdata & RTCA_MASK_SEC;
                  RTCA_ADDR_ALM_HOUR: next_st.alarm_hour    = bus_wdata & RTCA_MASK_HOUR;
                  RTCA_ADDR_ALM_DATE: next_st.alarm_date    = bus_wdata & RTCA_MASK_HOUR;
                  RTCA_ADDR_ALM_MON:  next_st.alarm_month   = bus_wdata & RTCA_MASK_MON;
                  RTCA_ADDR_ALM_YEAR: next_st.alarm_year    = bus_wdata & RTCA_MASK_YEAR;
                  default: ;
               endcase
            end
         end
         RTCA_BUS_READ: begin
            next_st.rvalid = 1'b1;
            unique case (le_addr)
               RTCA_ADDR_CONTROL:  next_st.rdata = st.rtc_control;
               // reload reads back, not the running count
               RTCA_ADDR_TICK:     next_st.rdata = st.tick_control;
               RTCA_ADDR_ALM_CTRL: next_st.rdata = st.alarm_control;
               RTCA_ADDR_ALM_SEC:  next_st.rdata = st.alarm_second;
               RTCA_ADDR_ALM_MIN:  next_st.rdata = st.alarm_minute;
               RTCA_ADDR_ALM_HOUR: next_st.rdata = st.alarm_hour;
               RTCA_ADDR_ALM_DATE: next_st.rdata = st.alarm_date;
               RTCA_ADDR_ALM_MON:  next_st.rdata = st.alarm_month;
               RTCA_ADDR_ALM_YEAR: next_st.rdata = st.alarm_year;
               default:            next_st.rdata = RTCA_RESET_ZERO;
            endcase
         end
         RTCA_BUS_IDLE: ;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st               <= '0;
         st.alarm_date    <= RTCA_RESET_ONE;
         st.alarm_month   <= RTCA_RESET_ONE;
      end else begin
         st <= next_st;
      end
   end

   // merge select passes to the counters
   assign counter_merge_select = st.rtc_control[RTCA_BIT_MERGE];
   assign cpu_access_enable    = st.rtc_control[RTCA_BIT_ACCESS_EN];
   assign count_chain_reset    = st.rtc_control[RTCA_BIT_CHAIN_RST];
   assign count_clock_source   = st.rtc_control[RTCA_BIT_CLK_SRC];
   assign second_advance       = st.sec_adv;
   assign tick_irq             = st.tick_irq;
   assign alarm_irq            = st.alarm_irq;
   assign power_wakeup_request = st.wakeup;
   assign bus_rdata            = st.rdata;
   assign bus_rvalid           = st.rvalid;
endmodule
`default_nettype wire

// ---- rtca_pkg.sv ----
/*
 Package for the clock control, tick and alarm block: register map, field
 positions, reset values and timing figures. Assumes a 10 MHz system clock.
*/
// Overview of operation
// - With access enable low, counting and reads continue; writes other than to control are refused.
// - Control bit 3 high holds the count chain in reset; resets to zero.
// - Control bit 2 zero merges counters; one selects separate counters for test.
// - Control bit 1 zero uses the divided crystal; one uses raw crystal for test.
// - Each register decodes at its little-endian address, or three bytes higher in big-endian mode.
// - Tick bit 7 enables the tick interrupt; resets to zero.
// - Tick bits 6:0 hold the reload; the running copy is not readable.
// - Alarm match raises the clock interrupt, and wakeup too in power-down.
// - Alarm control bit 6 is the global alarm enable; resets to zero.
// - Alarm control bits 5..0 enable year, month, date, hour, minute, second.
// - Alarm second holds BCD tens in 6:4, units in 3:0; resets zero.
// - Alarm minute uses the seconds layout and resets to zero.
// - Alarm hour holds tens in 5:4, units in 3:0; resets zero.
// - Alarm date holds tens in 5:4, units in 3:0; resets to 01.
// - Alarm month holds tens in bit 4, units in 3:0; resets to 01.
// - Alarm year holds two BCD digits in 7:0; resets zero.
// - Tick interrupt period is reload plus one, in 1/128 second units.
// - Tick counter interrupts on reaching zero, then reloads.
package rtca_pkg;
   localparam logic [31:0] RTCA_ADDR_CONTROL  = 32'h57000040;
   localparam logic [31:0] RTCA_ADDR_TICK     = 32'h57000044;
   localparam logic [31:0] RTCA_ADDR_ALM_CTRL = 32'h57000050;
   localparam logic [31:0] RTCA_ADDR_ALM_SEC  = 32'h57000054;
   localparam logic [31:0] RTCA_ADDR_ALM_MIN  = 32'h57000058;
   localparam logic [31:0] RTCA_ADDR_ALM_HOUR = 32'h5700005c;
   localparam logic [31:0] RTCA_ADDR_ALM_DATE = 32'h57000060;
   localparam logic [31:0] RTCA_ADDR_ALM_MON  = 32'h57000064;
   localparam logic [31:0] RTCA_ADDR_ALM_YEAR = 32'h57000068;
   localparam logic [31:0] RTCA_BIG_OFFSET    = 32'h00000003;

   // Writable-bit masks; reserved bits are outside them
   localparam logic [7:0] RTCA_MASK_CONTROL  = 8'h0f;
   localparam logic [7:0] RTCA_MASK_TICK     = 8'hff;
   localparam logic [7:0] RTCA_MASK_ALM_CTRL = 8'h7f;
   localparam logic [7:0] RTCA_MASK_SEC      = 8'h7f;
   localparam logic [7:0] RTCA_MASK_HOUR     = 8'h3f;
   localparam logic [7:0] RTCA_MASK_MON      = 8'h1f;
   localparam logic [7:0] RTCA_MASK_YEAR     = 8'hff;

   localparam logic [7:0] RTCA_RESET_ZERO = 8'h00;
   localparam logic [7:0] RTCA_RESET_ONE  = 8'h01;

   localparam int RTCA_BIT_ACCESS_EN = 0;
   localparam int RTCA_BIT_CLK_SRC   = 1;
   localparam int RTCA_BIT_MERGE     = 2;
   localparam int RTCA_BIT_CHAIN_RST = 3;
   localparam int RTCA_BIT_TICK_IE   = 7;
   localparam int RTCA_BIT_ALM_ON    = 6;
   localparam int RTCA_BIT_YEAR_ON   = 5;
   localparam int RTCA_BIT_MON_ON    = 4;
   localparam int RTCA_BIT_DATE_ON   = 3;
   localparam int RTCA_BIT_HOUR_ON   = 2;
   localparam int RTCA_BIT_MIN_ON    = 1;
   localparam int RTCA_BIT_SEC_ON    = 0;

   localparam logic [6:0] RTCA_TICK_ZERO = 7'h00;
   // Crystal divide: 2^15 edges per second, tick at 128 Hz = 2^8 edges
   localparam int RTCA_DIV_BITS  = 15;
   localparam int RTCA_TICK_BIT  = 7;
   localparam logic [14:0] RTCA_DIV_ZERO = 15'h0000;

   typedef enum logic [2:0] {
      RTCA_BUS_IDLE  = 3'b001,
      RTCA_BUS_WRITE = 3'b010,
      RTCA_BUS_READ  = 3'b100
   } rtca_bus_e;
endpackage

// ---- rtca_match.sv ----
/*
 One alarm field comparator. Assumes both bytes already have reserved bits
 cleared, so a plain compare is a BCD compare.
*/
`timescale 1ns/1ns
`default_nettype none
module rtca_match
   import rtca_pkg::*;
(
   // Field inputs
   input  wire logic [7:0] alarm_value,
   input  wire logic [7:0] time_value,
   input  wire logic       field_on,
   // Result
   output logic            field_ok
);
   assign field_ok = !field_on || (alarm_value == time_value);
endmodule
`default_nettype wire

// ---- rtca_tick.sv ----
/*
 Crystal prescaler and tick down-counter. Assumes xtal_edge is a one-cycle
 pulse per crystal period, synchronous to clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module rtca_tick
   import rtca_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Controls
   input  wire logic       xtal_edge,
   input  wire logic       chain_reset,
   input  wire logic       raw_clock,
   input  wire logic [6:0] reload,
   input  wire logic       reload_load,
   // Events
   output logic            second_pulse,
   output logic            tick_zero
);
   typedef struct packed {
      logic [14:0] div;
      logic [6:0]  count;
   } rtca_tick_s;

   rtca_tick_s st;
   rtca_tick_s next_st;
   logic       tick_edge;
   logic       div_wrap;

   always_comb begin
      next_st   = st;
      div_wrap  = xtal_edge && (st.div == {RTCA_DIV_BITS{1'b1}});
      tick_edge = xtal_edge && (st.div[RTCA_TICK_BIT:0] == {(RTCA_TICK_BIT+1){1'b1}});
      tick_zero = tick_edge && (st.count == RTCA_TICK_ZERO);
      second_pulse = raw_clock ? xtal_edge : div_wrap;
      if (xtal_edge) begin
         next_st.div = st.div + 15'h0001;
      end
      if (tick_edge) begin
         if (st.count == RTCA_TICK_ZERO) begin
            next_st.count = reload;
         end else begin
            next_st.count = st.count - 7'h01;
         end
      end
      if (reload_load) begin
         next_st.count = reload;
      end
      if (chain_reset) begin
         next_st.div  = RTCA_DIV_ZERO;
         second_pulse = 1'b0;
         tick_zero    = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule
`default_nettype wire

// ---- rtca_top_props.sv ----
/*
 Port checker for rtca_top: bus answers, control fields and event pulses.
 Assumes one clock and the asynchronous reset of the block; bound below.
*/
`timescale 1ns/1ns
`default_nettype none
module rtca_top_props
   import rtca_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset,
   // Processor byte port
   input wire logic [31:0] bus_addr,
   input wire logic        bus_write,
   input wire logic        bus_read,
   input wire logic        bus_big_endian,
   input wire logic [7:0]  bus_wdata,
   input wire logic [7:0]  bus_rdata,
   input wire logic        bus_rvalid,
   // Power state, controls and events
   input wire logic        power_down,
   input wire logic        cpu_access_enable,
   input wire logic        count_chain_reset,
   input wire logic        counter_merge_select,
   input wire logic        count_clock_source,
   input wire logic        tick_irq,
   input wire logic        alarm_irq,
   input wire logic        power_wakeup_request
);
   logic [31:0] ctl_addr;
   assign ctl_addr = RTCA_ADDR_CONTROL + (bus_big_endian ? RTCA_BIG_OFFSET : 32'h0);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_ctl_wr;
      bus_write && bus_addr == ctl_addr;
   endsequence
   sequence s_ctl_rd;
      bus_read && !bus_write && bus_addr == ctl_addr;
   endsequence
   AST_CHAIN_RST: assert property (s_ctl_wr |=> count_chain_reset == $past(bus_wdata[3]))
      else $error("chain reset bit not taken from write");
   AST_TEST_SEL: assert property (s_ctl_wr |=> counter_merge_select == $past(bus_wdata[2])
      && count_clock_source == $past(bus_wdata[1])) else $error("test selects wrong");
   AST_ACCESS_EN: assert property (s_ctl_wr |=> cpu_access_enable == $past(bus_wdata[0]))
      else $error("access enable write lost");
   AST_CTL_READ: assert property (s_ctl_rd |=> bus_rvalid && bus_rdata == {4'h0,
      count_chain_reset, counter_merge_select, count_clock_source, cpu_access_enable})
      else $error("control read data wrong");
   AST_READ_ANSWER: assert property (bus_read && !bus_write |=> bus_rvalid)
      else $error("read not answered");
   AST_RVALID_CAUSE: assert property (bus_rvalid |-> $past(bus_read))
      else $error("read valid without read");
   AST_WAKE_CAUSE: assert property (power_wakeup_request |-> alarm_irq && $past(power_down))
      else $error("wakeup outside power-down alarm");
   AST_WAKE_ON_PD: assert property (alarm_irq && $past(power_down) |-> power_wakeup_request)
      else $error("power-down alarm without wakeup");
   AST_ALARM_PULSE: assert property (alarm_irq |=> !alarm_irq)
      else $error("alarm pulse too long");
   AST_TICK_PULSE: assert property (tick_irq |=> !tick_irq)
      else $error("tick pulse too long");
endmodule
bind rtca_top rtca_top_props props_u (.clk_sys(clk_sys), .reset(reset),
   .bus_addr(bus_addr), .bus_write(bus_write), .bus_read(bus_read),
   .bus_big_endian(bus_big_endian), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .bus_rvalid(bus_rvalid), .power_down(power_down), .cpu_access_enable(cpu_access_enable),
   .count_chain_reset(count_chain_reset), .counter_merge_select(counter_merge_select),
   .count_clock_source(count_clock_source), .tick_irq(tick_irq), .alarm_irq(alarm_irq),
   .power_wakeup_request(power_wakeup_request));
`default_nettype wire

// ---- rtca_cpu_model.sv ----
/*
 Processor model: byte stores and loads on the clock's register port.
 Assumes the bench calls its tasks; signals change on falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module rtca_cpu_model
   import rtca_pkg::*;
(
   // Clock
   input  wire logic        clk_sys,
   // Byte port
   output logic [31:0]      bus_addr,
   output logic             bus_write,
   output logic             bus_read,
   output logic             bus_big_endian,
   output logic [7:0]       bus_wdata,
   input  wire logic [7:0]  bus_rdata,
   input  wire logic        bus_rvalid
);
   initial begin
      bus_addr = 32'h0;
      bus_write = 1'b0;
      bus_read = 1'b0;
      bus_big_endian = 1'b0;
      bus_wdata = 8'h00;
   end
   // One byte store, address moved by three in big-endian mode
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic big);
      @(negedge clk_sys);
      bus_addr = a + (big ? RTCA_BIG_OFFSET : 32'h0);
      bus_big_endian = big;
      bus_wdata = d;
      bus_write = 1'b1;
      @(negedge clk_sys);
      bus_write = 1'b0;
      // Released data is inverted so a stale byte cannot pass for a good one
      bus_wdata = ~d;
   endtask
   // One byte load; answer sampled on the falling edge half a cycle after the load is taken
   task automatic rd(input logic [31:0] a, input logic big, output logic [7:0] d,
                     output logic v);
      @(negedge clk_sys);
      bus_addr = a + (big ? RTCA_BIG_OFFSET : 32'h0);
      bus_big_endian = big;
      bus_read = 1'b1;
      @(negedge clk_sys);
      bus_read = 1'b0;
      d = bus_rdata;
      v = bus_rvalid;
   endtask
endmodule
`default_nettype wire

// ---- tb_rtca_top.sv ----
/*
 Testbench for rtca_top: registers, write lock, tick period and alarm.
 Assumes the processor model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_rtca_top
   import rtca_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        xtal_edge = 1'b0;
   logic        xtal_run = 1'b0;
   logic        power_down = 1'b0;
   logic [7:0]  tm [6] = '{8'h00, 8'h15, 8'h00, 8'h01, 8'h01, 8'h99};
   wire  [31:0] addr;
   wire  [7:0]  wdata, rdata;
   wire         wr, rd, big, rvalid, en, crst, msel, csrc, alarm_irq, wake;
   logic        tick_irq, sec_adv;
   int          bad_count = 0;
   int          checks = 0;
   int          n;
   localparam logic [31:0] ADR [9] = '{RTCA_ADDR_CONTROL, RTCA_ADDR_TICK, RTCA_ADDR_ALM_CTRL,
      RTCA_ADDR_ALM_SEC, RTCA_ADDR_ALM_MIN, RTCA_ADDR_ALM_HOUR, RTCA_ADDR_ALM_DATE,
      RTCA_ADDR_ALM_MON, RTCA_ADDR_ALM_YEAR};
   localparam logic [7:0] RST [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
      8'h00};
   localparam logic [7:0] ALL [9] = '{8'h0f, 8'hff, 8'h7f, 8'h7f, 8'h7f, 8'h3f, 8'h3f, 8'h1f,
      8'hff};

   always #50 clk_sys = ~clk_sys;
   // Crystal pulse every second cycle keeps the tick period short in cycles
   always @(negedge clk_sys) xtal_edge <= xtal_run & ~xtal_edge;

   rtca_cpu_model cpu_u (.clk_sys(clk_sys), .bus_addr(addr), .bus_write(wr), .bus_read(rd),
      .bus_big_endian(big), .bus_wdata(wdata), .bus_rdata(rdata), .bus_rvalid(rvalid));
   rtca_top dut_u (.clk_sys(clk_sys), .reset(reset), .bus_addr(addr), .bus_write(wr),
      .bus_read(rd), .bus_big_endian(big), .bus_wdata(wdata), .bus_rdata(rdata),
      .bus_rvalid(rvalid), .xtal_edge(xtal_edge), .power_down(power_down),
      .seconds_bcd(tm[0]), .minutes_bcd(tm[1]), .hours_bcd(tm[2]), .day_of_month_bcd(tm[3]),
      .month_bcd(tm[4]), .year_bcd(tm[5]), .cpu_access_enable(en), .count_chain_reset(crst),
      .counter_merge_select(msel), .count_clock_source(csrc), .second_advance(sec_adv),
      .tick_irq(tick_irq), .alarm_irq(alarm_irq), .power_wakeup_request(wake));

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic b, input logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      cpu_u.rd(a, b, d, v);
      chk({31'h0, v}, 32'h1, "read valid");
      chk({24'h0, d}, {24'h0, exp}, "read data");
   endtask
   // Counts cycles until the pulse shows; running out ends the run
   task automatic wait_hi(ref logic s, input int lim, output int k);
      k = 0;
      while (s !== 1'b1 && k < lim) begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= lim) begin
         bad_count++;
         $display("Error %0t wait for pulse ran out", $time);
         final_report();
      end
   endtask
   task automatic count_hi(ref logic s, input int cyc, output int k);
      k = 0;
      repeat (cyc) begin
         @(negedge clk_sys);
         k += (s === 1'b1);
      end
   endtask
   task automatic alarm_try(input logic [7:0] ctl, input logic pd, input int ei, input int ew);
      int h;
      int w;
      tm[0] = 8'h00;
      cpu_u.wr(RTCA_ADDR_ALM_CTRL, ctl, 1'b0);
      power_down = pd;
      repeat (3) @(negedge clk_sys);
      tm[0] = 8'h30;
      h = 0;
      w = 0;
      repeat (4) begin
         @(negedge clk_sys);
         h += (alarm_irq === 1'b1);
         w += (wake === 1'b1);
      end
      chk(h, ei, "alarm pulses");
      chk(w, ew, "wakeup pulses");
   endtask

   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      for (int i = 0; i < 9; i++) rd_chk(ADR[i], 1'b0, RST[i]);
      cpu_u.wr(RTCA_ADDR_ALM_SEC, 8'h25, 1'b0);
      rd_chk(RTCA_ADDR_ALM_SEC, 1'b0, 8'h00);
      rd_chk(32'h57000048, 1'b0, 8'h00);
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h01, 1'b0);
      chk({31'h0, en}, 32'h1, "access enable");
      $display("reset values and write lock done");
      for (int i = 0; i < 9; i++) cpu_u.wr(ADR[i], 8'hff, 1'b0);
      for (int i = 0; i < 9; i++) rd_chk(ADR[i], 1'b1, ALL[i]);
      chk({28'h0, crst, msel, csrc, en}, 32'hf, "control outputs");
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h01, 1'b1);
      $display("register access done");
      xtal_run = 1'b1;
      cpu_u.wr(RTCA_ADDR_TICK, 8'h81, 1'b0);
      wait_hi(tick_irq, 3000, n);
      @(negedge clk_sys);
      wait_hi(tick_irq, 3000, n);
      chk(n + 1, 1024, "tick period");
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h09, 1'b0);
      count_hi(tick_irq, 1100, n);
      chk(n, 0, "ticks while chain reset");
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h03, 1'b0);
      count_hi(sec_adv, 100, n);
      chk(n, 50, "second advance on raw crystal");
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h01, 1'b0);
      cpu_u.wr(RTCA_ADDR_TICK, 8'h01, 1'b0);
      count_hi(tick_irq, 1100, n);
      chk(n, 0, "ticks while disabled");
      $display("tick done");
      cpu_u.wr(RTCA_ADDR_ALM_SEC, 8'h30, 1'b0);
      cpu_u.wr(RTCA_ADDR_ALM_MIN, 8'h15, 1'b0);
      cpu_u.wr(RTCA_ADDR_ALM_YEAR, 8'h00, 1'b0);
      alarm_try(8'h43, 1'b0, 1, 0);
      alarm_try(8'h43, 1'b1, 1, 1);
      alarm_try(8'h03, 1'b1, 0, 0);
      alarm_try(8'h63, 1'b0, 0, 0);
      alarm_try(8'h41, 1'b0, 1, 0);
      $display("alarm done");
      cpu_u.wr(RTCA_ADDR_CONTROL, 8'h00, 1'b0);
      chk({31'h0, en}, 32'h0, "access enable cleared");
      cpu_u.wr(RTCA_ADDR_ALM_SEC, 8'h55, 1'b0);
      rd_chk(RTCA_ADDR_ALM_SEC, 1'b0, 8'h30);
      $display("power-off lock done");
      final_report();
   end
endmodule
`default_nettype wire
